// file: design/tx_digital_modulator_shaping.v
// transmit modulator: rate generator, shaping, amplitude keying, polar and test sources
// Function
// - gaussian shaping with bt selectable as 1 or 0.5 in gfsk modes
// - gaussian filter gives one output value per symbol from an eight-symbol history
// - frequency interpolation factor 64, halved per exponent above 5, off at 11
// - isi equalizer control can disable it or choose single or dual pass
// - ook/ask: one at max index level, zero at entry 0
// - nonzero symbol map select inverts the amplitude bit mapping
// - ask ramps entry 0 to max for one, reverse for zero; step width plus one eighths of a symbol
// - repeated ones hold maximum, repeated zeros hold minimum power
// - power interpolation between table values with the same factor rule
// - for exponent 5 or more amplifier ticks 8 to 4 clocks apart
// - smoothing fir for ook: filter, ramp or switch configurations; FIR_RAMP switches between entry 0 and max the same as switch
// - polar mode reads one byte per sample tick, so byte pairs at four times the data rate
// - polar first byte signed; deviation times value over 128
// - polar second byte drives amplifier power directly
// - polar never stops alone; only abort; host refills queue beyond 32
// - modulation byte 0x77 gives continuous carrier until abort
// - source select 3 gives continuous pn9 data until abort
// - symbol rate from mantissa and exponent, integer divider at exponent 15
// - fractional divider below exponent 15, jitter-free integer divider at 15
`include "tx_mod_consts.vh"
module tx_digital_modulator_shaping (
    input wire clk,
    input wire nrst,
    input wire txStart,
    input wire abort_command,
    input wire [7:0] modulation_select,
    input wire [1:0] tx_source_select,
    input wire gauss_bt_select,
    input wire freq_interp_enable,
    input wire power_interp_enable,
    input wire [3:0] rate_exponent_field,
    input wire [15:0] rate_mantissa,
    input wire [1:0] isi_equalizer_control,
    input wire [1:0] symbol_map_select,
    input wire [63:0] power_level_table,
    input wire [2:0] max_level_index,
    input wire [1:0] ramp_step_width,
    input wire smoothing_fir_enable,
    input wire [1:0] fir_mode,
    input wire digital_ramp_enable,
    input wire [1:0] bessel_cutoff_select,
    input wire [15:0] freq_deviation,
    input wire [7:0] txData,
    input wire txDataValid,
    output wire txDataReady,
    output reg txBusy,
    output reg [15:0] freqWord,
    output reg [7:0] powerWord,
    output reg sampleTick,
    output reg [1:0] equalizerMode,
    output reg [1:0] besselCutoff,
    output reg [5:0] queueLevel
);
    // stored power table entry i lives at bits 8i+7:8i
    function [7:0] tableEntry;
        input [63:0] tab;
        input [2:0] idx;
        begin
            tableEntry = tab[idx*8 +: 8];
        end
    endfunction
    // log2 of interpolation factor; zero means no interpolation
    function [2:0] interpLog;
        input [3:0] e;
        begin
            if (e < `EXP_INTERP_SCALE) begin
                interpLog = `INTERP_BASE_LOG;
            end else if (e >= `EXP_NO_INTERP) begin
                interpLog = 3'h0;
            end else begin
                interpLog = `INTERP_BASE_LOG - e[2:0] + 3'h5;
            end
        end
    endfunction
    // one linear interpolation step: signed difference scaled down by the factor
    function [16:0] interpStep;
        input [16:0] diff;
        input [2:0] lg;
        begin
            interpStep = $signed(diff) >>> lg;
        end
    endfunction

    wire [7:0] fifoOut;
    wire fifoValid;
    reg fifoPop;
    wire [5:0] fifoLevel;
    tx_mod_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) queue (
        .clk(clk),
        .nrst(nrst),
        .inData(txData),
        .inValid(txDataValid),
        .inReady(txDataReady),
        .outData(fifoOut),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .level(fifoLevel)
    );

    // rate generator: phase accumulator below exponent 15, integer counter at 15
    reg [32:0] phaseAcc;
    reg [18:0] intCount;
    wire [3:0] e = rate_exponent_field;
    // sample rate is eight times the symbol rate; exponent 14 saturates at one tick per clock
    wire [4:0] stepShift = {1'b0, e} + 5'h3;
    wire [35:0] stepWide = (e == 4'h0) ? {16'h0, rate_mantissa, 4'h0} :
        ({19'h0, 1'b1, rate_mantissa} << stepShift);
    wire [32:0] sampleStep = (stepWide[35:33] != 3'h0) ? {33{1'b1}} : stepWide[32:0];
    wire [33:0] accSum = {1'b0, phaseAcc} + {1'b0, sampleStep};
    wire fracTick = accSum[33];
    wire intTick = (intCount == 19'h0) && (rate_mantissa != 16'h0);
    wire rateTick = (e == `EXP_INTEGER) ? intTick : fracTick;

    // amplifier update ticks every clock below exponent 5, clamped to 4..8 clocks at high rates
    reg [3:0] ampDiv;
    // span falls with the mantissa: 8 clocks at zero, 4 at full scale
    wire [16:0] mantPlus = {1'b0, rate_mantissa} + 17'h1;
    wire [3:0] ampSpan = 4'h8 - {1'b0, mantPlus[16:14]};
    wire ampTick = (e >= `EXP_INTERP_SCALE) ? (ampDiv == 4'h0) : 1'b1;

    reg [2:0] phase;
    reg [8:0] pn9;
    reg curBit;
    reg prevBit;
    reg [7:0] gaussHist;
    reg [3:0] stepCount;
    reg [2:0] rampIdx;
    reg [7:0] powerTarget;
    reg [7:0] interpPower;
    reg [15:0] freqTarget;
    reg [15:0] interpFreq;
    reg [7:0] polarFreq;
    reg polarHalf;
    reg [7:0] firHist;

    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_CW = 3'b100;
    reg [2:0] state;
    reg [2:0] next_state;

    wire isCw = (modulation_select == `MOD_CW_BYTE);
    wire [2:0] modType = modulation_select[2:0];
    wire isPolar = (modType == `MOD_POLAR);
    wire isAsk = (modType == `MOD_ASK);
    wire isGauss = (modType == `MOD_2GFSK) || (modType == `MOD_4GFSK);
    wire usePn9 = (tx_source_select == `SRC_PN9);
    wire mapBit = curBit ^ (symbol_map_select != 2'h0);
    wire [7:0] pMax = tableEntry(power_level_table, max_level_index);
    wire [7:0] pMin = tableEntry(power_level_table, 3'h0);

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (txStart) begin
                    next_state = isCw ? ST_CW : ST_RUN;
                end
            end
            ST_RUN: begin
                if (abort_command) begin
                    next_state = ST_IDLE;
                end
            end
            ST_CW: begin
                if (abort_command) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // gaussian tap weights over an 8-bit history; bt 0.5 spreads wider
    reg [15:0] gaussOut;
    integer k;
    always @* begin
        gaussOut = 16'h0;
        for (k = 0; k < 8; k = k + 1) begin
            if (gaussHist[k]) begin
                if (gauss_bt_select) begin
                    gaussOut = gaussOut + ((k >= 2 && k <= 5) ? (freq_deviation >> 2) : 16'h0);
                end else begin
                    gaussOut = gaussOut + ((k >= 1 && k <= 6) ? (freq_deviation / 16'h6) : 16'h0);
                end
            end
        end
    end

    // smoothing fir: eight-times oversampled moving average of the bit
    reg [3:0] firOnes;
    integer j;
    always @* begin
        firOnes = 4'h0;
        for (j = 0; j < 8; j = j + 1) begin
            firOnes = firOnes + {3'h0, firHist[j]};
        end
    end

    wire running = (state == ST_RUN);
    wire [2:0] iLog = interpLog(e);
    wire [8:0] powDiff = {1'b0, powerTarget} - {1'b0, interpPower};
    wire [16:0] frqDiff = {1'b0, freqTarget} - {1'b0, interpFreq};
    wire [16:0] powStep = interpStep({{8{powDiff[8]}}, powDiff}, iLog);
    wire [16:0] frqStep = interpStep(frqDiff, iLog);
    wire [32:0] polarProd = $signed({{8{polarFreq[7]}}, polarFreq}) * $signed({1'b0, freq_deviation});
    wire [11:0] firProd = pMax * firOnes;

    always @* begin
        // outside polar and carrier modes one byte per symbol is taken unless pn9 is the source, so the queue drains
        fifoPop = running && rateTick && fifoValid &&
            (isPolar || (phase == `PHASES && !usePn9));
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            phaseAcc <= 33'h0;
            intCount <= 19'h0;
            ampDiv <= 4'h0;
            phase <= 3'h0;
            pn9 <= `PN9_SEED;
            curBit <= 1'b0;
            prevBit <= 1'b0;
            gaussHist <= 8'h0;
            stepCount <= 4'h0;
            rampIdx <= 3'h0;
            powerTarget <= 8'h0;
            interpPower <= 8'h0;
            freqTarget <= 16'h0;
            interpFreq <= 16'h0;
            polarFreq <= 8'h0;
            polarHalf <= 1'b0;
            firHist <= 8'h0;
            txBusy <= 1'b0;
            freqWord <= 16'h0;
            powerWord <= 8'h0;
            sampleTick <= 1'b0;
            equalizerMode <= `EQU_OFF;
            besselCutoff <= 2'h0;
            queueLevel <= 6'h0;
        end else begin
            state <= next_state;
            txBusy <= (next_state != ST_IDLE);
            equalizerMode <= isi_equalizer_control;
            besselCutoff <= bessel_cutoff_select;
            queueLevel <= fifoLevel;
            phaseAcc <= accSum[32:0];
            if (intTick || intCount == 19'h0) begin
                // one sample every mantissa clocks, eight samples per symbol
                intCount <= {3'h0, rate_mantissa} - 19'h1;
            end else begin
                intCount <= intCount - 19'h1;
            end
            ampDiv <= (ampDiv == 4'h0) ? ampSpan - 4'h1 : ampDiv - 4'h1;
            sampleTick <= rateTick && (state != ST_IDLE);
            // outputs drop on the abort edge itself, not one cycle later
            if (next_state == ST_IDLE || state == ST_IDLE) begin
                powerWord <= 8'h0;
                freqWord <= 16'h0;
                polarHalf <= 1'b0;
                phase <= 3'h0;
                stepCount <= 4'h0;
                rampIdx <= 3'h0;
            end else if (state == ST_CW) begin
                freqWord <= 16'h0;
                powerWord <= pMax;
            end else if (isPolar) begin
                if (fifoPop) begin
                    polarHalf <= ~polarHalf;
                    if (!polarHalf) begin
                        polarFreq <= fifoOut;
                    end else begin
                        // signed sample scaled by deviation over 128
                        freqWord <= polarProd[22:7];
                        powerWord <= fifoOut;
                    end
                end
            end else begin
                if (rateTick) begin
                    phase <= phase + 3'h1;
                    firHist <= {firHist[6:0], mapBit};
                    if (phase == `PHASES) begin
                        prevBit <= mapBit;
                        curBit <= usePn9 ? pn9[0] : (fifoValid ? fifoOut[0] : 1'b0);
                        pn9 <= {pn9[0] ^ pn9[5], pn9[8:1]};
                        gaussHist <= {gaussHist[6:0], mapBit};
                    end
                    freqTarget <= isGauss ? gaussOut : (mapBit ? freq_deviation : 16'h0);
                    if (isAsk) begin
                        if (smoothing_fir_enable) begin
                            case (fir_mode)
                                `FIR_FILTER: powerTarget <= firProd[10:3];
                                `FIR_RAMP: powerTarget <= mapBit ? pMax : pMin;
                                default: powerTarget <= mapBit ? pMax : pMin;
                            endcase
                        end else if (digital_ramp_enable && mapBit != prevBit) begin
                            // ramp steps last ramp_step_width+1 eighths of a symbol
                            if (stepCount >= {2'h0, ramp_step_width}) begin
                                stepCount <= 4'h0;
                                if (mapBit && rampIdx != max_level_index) begin
                                    rampIdx <= rampIdx + 3'h1;
                                end else if (!mapBit && rampIdx != 3'h0) begin
                                    rampIdx <= rampIdx - 3'h1;
                                end
                            end else begin
                                stepCount <= stepCount + 4'h1;
                            end
                            powerTarget <= tableEntry(power_level_table, rampIdx);
                        end else begin
                            rampIdx <= mapBit ? max_level_index : 3'h0;
                            powerTarget <= mapBit ? pMax : pMin;
                        end
                    end else begin
                        powerTarget <= pMax;
                    end
                end
                if (ampTick) begin
                    if (power_interp_enable && iLog != 3'h0) begin
                        interpPower <= interpPower + powStep[7:0];
                    end else begin
                        interpPower <= powerTarget;
                    end
                    if (freq_interp_enable && isGauss && iLog != 3'h0) begin
                        interpFreq <= interpFreq + frqStep[15:0];
                    end else begin
                        interpFreq <= freqTarget;
                    end
                    powerWord <= interpPower;
                    freqWord <= interpFreq;
                end
            end
        end
    end
endmodule

// file: design/tx_mod_consts.vh
// constants for the transmit digital modulator
`ifndef TX_MOD_CONSTS_VH
`define TX_MOD_CONSTS_VH
`define MOD_2FSK 3'h0
`define MOD_4FSK 3'h1
`define MOD_2GFSK 3'h2
`define MOD_4GFSK 3'h3
`define MOD_ASK 3'h5
`define MOD_POLAR 3'h6
`define MOD_CW 3'h7
`define MOD_CW_BYTE 8'h77
`define SRC_PN9 2'h3
`define PN9_SEED 9'h1ff
`define FIR_FILTER 2'h0
`define FIR_RAMP 2'h1
`define FIR_SWITCH 2'h2
`define EQU_OFF 2'h0
`define EQU_SINGLE 2'h1
`define EQU_DUAL 2'h2
`define PHASES 3'h7
`define INTERP_BASE_LOG 3'h6
`define EXP_NO_INTERP 4'hb
`define EXP_INTERP_SCALE 4'h5
`define EXP_INTEGER 4'hf
`define FIFO_DEPTH 32
`define FIFO_AW 5
`endif

// file: design/tx_mod_fifo.v
// parameterised valid/ready fifo in flip-flops
module tx_mod_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire nrst,
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output wire inReady,
    output wire [WIDTH-1:0] outData,
    output wire outValid,
    input wire outReady,
    output wire [AW:0] level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    reg [AW:0] count;
    wire doWrite = inValid && inReady;
    wire doRead = outValid && outReady;
    assign inReady = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData = mem[rdPtr];
    assign level = count;
    always @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWrite && !doRead) begin
                count <= count + 1'b1;
            end else if (doRead && !doWrite) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// file: tb/tx_mod_props.sv
// port-level assertions for the transmit modulator
module tx_mod_props (
    input wire clk,
    input wire nrst,
    input wire txStart,
    input wire abort_command,
    input wire [1:0] isi_equalizer_control,
    input wire [1:0] bessel_cutoff_select,
    input wire [3:0] rate_exponent_field,
    input wire [15:0] rate_mantissa,
    input wire txDataReady,
    input wire txBusy,
    input wire [15:0] freqWord,
    input wire [7:0] powerWord,
    input wire sampleTick,
    input wire [1:0] equalizerMode,
    input wire [1:0] besselCutoff,
    input wire [5:0] queueLevel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_gap;
        (!sampleTick) [*7] ##1 (sampleTick || !txBusy);
    endsequence
    sequence s_idle;
        (!txBusy) [*3];
    endsequence
    property p_start;
        !txBusy && txStart && !abort_command |=> txBusy;
    endproperty
    a_start: assert property (p_start) else $error("busy missing after start");
    property p_abort;
        abort_command && txBusy |=> !txBusy && powerWord == 8'h0 && freqWord == 16'h0;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not clear outputs");
    property p_hold;
        txBusy && !abort_command |=> txBusy;
    endproperty
    a_hold: assert property (p_hold) else $error("transmit ended without abort");
    property p_quiet;
        s_idle |-> !sampleTick;
    endproperty
    a_quiet: assert property (p_quiet) else $error("sample tick while idle");
    property p_equ;
        $stable(isi_equalizer_control) [*2] |-> equalizerMode == isi_equalizer_control;
    endproperty
    a_equ: assert property (p_equ) else $error("equalizer mode wrong");
    property p_bessel;
        $changed(bessel_cutoff_select) ##1 $stable(bessel_cutoff_select) |-> besselCutoff == bessel_cutoff_select;
    endproperty
    a_bessel: assert property (p_bessel) else $error("cutoff select wrong");
    property p_full;
        !txBusy && queueLevel == 6'd32 |-> !txDataReady;
    endproperty
    a_full: assert property (p_full) else $error("full queue still ready");
    property p_gap;
        sampleTick && rate_exponent_field == 4'hf && rate_mantissa == 16'h8 |=> s_gap;
    endproperty
    a_gap: assert property (p_gap) else $error("integer divider spacing wrong");
endmodule

bind tx_digital_modulator_shaping tx_mod_props i_tx_mod_props (.*);

// file: tb/tx_front_model.sv
// synthesizer and amplifier stand-in: latches each sample word
module tx_front_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sampleTick,
    input wire logic [15:0] freqWord,
    input wire logic [7:0] powerWord,
    output logic [15:0] heldFreq,
    output logic [7:0] heldPower,
    output logic newSample
);
    timeunit 1ns;
    timeprecision 1ps;
    // only a change of power marks a new pair, so held samples are not counted twice
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            heldFreq <= 16'h0;
            heldPower <= 8'h0;
            newSample <= 1'b0;
        end else begin
            newSample <= sampleTick && (powerWord != heldPower);
            if (sampleTick) begin
                heldFreq <= freqWord;
                heldPower <= powerWord;
            end
        end
    end
endmodule

// file: tb/testbench.sv
// self-checking bench for the transmit modulator
`include "tx_mod_consts.vh"
module testbench;
timeunit 1ns;
timeprecision 1ps;
logic clk, nrst, txStart, abort_command, gauss_bt_select, freq_interp_enable, power_interp_enable;
logic smoothing_fir_enable, digital_ramp_enable, txDataValid, polarOn;
logic [7:0] modulation_select, txData;
logic [1:0] tx_source_select, isi_equalizer_control, symbol_map_select, ramp_step_width, fir_mode;
logic [1:0] bessel_cutoff_select;
logic [3:0] rate_exponent_field;
logic [15:0] rate_mantissa, freq_deviation;
logic [63:0] power_level_table;
logic [2:0] max_level_index;
wire txDataReady, txBusy, sampleTick, newSample;
wire [15:0] freqWord, heldFreq;
wire [7:0] powerWord, heldPower;
wire [1:0] equalizerMode, besselCutoff;
wire [5:0] queueLevel;
logic [31:0] seed = 32'd12604;
logic [23:0] expQ[$];
logic [23:0] e;
int bad_count, n_checks;
tx_digital_modulator_shaping i_tx_digital_modulator_shaping (.*);
tx_front_model i_tx_front_model (.*);
initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end
function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
endfunction
task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
        bad_count++;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
endtask
task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
        $display("Regression OK");
    end else begin
        $display("Regression broken");
    end
    $finish;
endtask
task automatic ticks(input int n);
    int k;
    k = 0;
    for (int i = 0; i < 4000 && k < n; i++) begin
        @(negedge clk);
        if (sampleTick === 1'b1) k++;
    end
    chk(16'(k), 16'(n));
    if (k < n) close_out();
endtask
// valid stays up between bytes; caller lowers it after the last one
task automatic push(input logic [7:0] b);
    txData = b;
    txDataValid = 1'b1;
    @(negedge clk);
endtask
task automatic start(input logic [7:0] mode);
    modulation_select = mode;
    @(negedge clk);
    txStart = 1'b1;
    @(negedge clk);
    txStart = 1'b0;
    chk(16'(txBusy), 16'h1);
endtask
task automatic stop();
    abort_command = 1'b1;
    @(negedge clk);
    abort_command = 1'b0;
    chk(16'(txBusy), 16'h0);
    chk(16'(powerWord), 16'h0);
    @(negedge clk);
endtask
always @(negedge clk) begin
    if (polarOn && newSample === 1'b1) begin
        if (expQ.size() > 0) begin
            e = expQ.pop_front();
            chk(heldFreq, e[23:8]);
            chk(16'(heldPower), 16'(e[7:0]));
        end else begin
            chk(16'h1, 16'h0);
        end
    end
end
initial begin
    logic [7:0] fb;
    logic [7:0] lvl;
    int m, hi, lo;
    {txStart, abort_command, freq_interp_enable, power_interp_enable, smoothing_fir_enable} = '0;
    {digital_ramp_enable, txDataValid, txData, modulation_select, tx_source_select, polarOn} = '0;
    {isi_equalizer_control, symbol_map_select, ramp_step_width, fir_mode, bessel_cutoff_select} = '0;
    {power_level_table, max_level_index} = '0;
    rate_exponent_field = `EXP_INTEGER;
    // integer divider: one sample every eight clocks
    rate_mantissa = 16'h8;
    freq_deviation = 16'h0100;
    nrst = 1'b0;
    m = rnd();
    gauss_bt_select = m[0];
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chk(16'({txBusy, powerWord, queueLevel}), 16'h0);
    chk(freqWord, 16'h0);
    for (int c = 0; c < 4; c++) begin
        isi_equalizer_control = 2'(c % 3);
        bessel_cutoff_select = 2'(3 - c);
        repeat (2) @(negedge clk);
        chk(16'(equalizerMode), 16'(c % 3));
        chk(16'(besselCutoff), 16'(3 - c));
    end
    // fill the queue with pairs before starting, so full and refusal are seen
    for (int i = 0; i < 16; i++) begin
        m = rnd();
        fb = m[7:0];
        expQ.push_back({16'($signed(fb) * 2), 8'(8 * i + 7)});
        push(fb);
        push(8'(8 * i + 7));
    end
    txDataValid = 1'b0;
    chk(16'(txDataReady), 16'h0);
    // the level port is registered, so it lags the last write by one clock
    @(negedge clk);
    chk(16'(queueLevel), 16'h20);
    push(8'h55);
    txDataValid = 1'b0;
    chk(16'(queueLevel), 16'h20);
    polarOn = 1'b1;
    start({5'h0, `MOD_POLAR});
    ticks(40);
    chk(16'(expQ.size()), 16'h0);
    chk(16'(txBusy), 16'h1);
    stop();
    polarOn = 1'b0;
    for (int k = 0; k < 4; k++) begin
        power_level_table = {rnd(), rnd()};
        m = rnd() % 7 + 1;
        max_level_index = 3'(m);
        symbol_map_select = k[1] ? 2'(m % 3 + 1) : 2'h0;
        smoothing_fir_enable = k[1];
        digital_ramp_enable = !k[1];
        fir_mode = `FIR_SWITCH;
        // two equal symbols, drained by tick 16, so the run settles at its steady level
        for (int i = 0; i < 2; i++) begin
            push(k[0] ? 8'hff : 8'h00);
        end
        txDataValid = 1'b0;
        start({5'h0, `MOD_ASK});
        ticks(20);
        lvl = (k[0] ^ k[1]) ? power_level_table[8 * m +: 8] : power_level_table[7:0];
        chk(16'(powerWord), 16'(lvl));
        stop();
    end
    start(`MOD_CW_BYTE);
    ticks(30);
    chk(16'(txBusy), 16'h1);
    chk(16'(powerWord), 16'(power_level_table[8 * m +: 8]));
    chk(freqWord, 16'h0);
    stop();
    tx_source_select = `SRC_PN9;
    symbol_map_select = 2'h0;
    power_level_table[7:0] = 8'h0;
    power_level_table[8 * m + 7] = 1'b1;
    hi = 0;
    lo = 0;
    start({5'h0, `MOD_ASK});
    for (int i = 0; i < 60; i++) begin
        ticks(1);
        // skip the first two symbols so the idle zero level cannot count
        if (i >= 16 && powerWord === power_level_table[8 * m +: 8]) hi++;
        if (i >= 16 && powerWord === 8'h0) lo++;
    end
    chk(16'(hi > 0), 16'h1);
    chk(16'(lo > 0), 16'h1);
    chk(16'(txBusy), 16'h1);
    stop();
    // gaussian shaping: deviation stays within the programmed peak and is nonzero at some sample
    freq_interp_enable = 1'b1;
    hi = 0;
    start({5'h0, `MOD_2GFSK});
    for (int i = 0; i < 60; i++) begin
        ticks(1);
        chk(16'(freqWord > freq_deviation), 16'h0);
        if (freqWord !== 16'h0) hi++;
    end
    chk(16'(hi > 0), 16'h1);
    stop();
    close_out();
end
endmodule
